// File: design/rf_frontend_mode_control.sv
// Operating-mode controller: power-down, ready and wake-up modes
//
// Our own choices: the address-and-strobe port and the placing of the registers.
module rf_frontend_mode_control
    import rf_mode_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire reg_req_t          reg_req_i,
    output logic [DATA_W-1:0]      rdata_o,
    input  wire logic              osc_ok_i,
    input  wire logic              rc_clk_i,
    input  wire logic              meas_done_i,
    input  wire logic [7:0]        meas_value_i,
    input  wire logic [DATA_W-1:0] fifo_rdata_i,
    output power_ctl_t             power_ctl_o,
    output op_mode_t               mode_o,
    output logic                   meas_start_o,
    output logic [1:0]             meas_sel_o,
    output logic                   fifo_push_o,
    output logic                   fifo_pop_o,
    output logic [DATA_W-1:0]      fifo_wdata_o,
    output logic                   irq_o
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic op_mode_t decode_mode(input logic [7:0] op);
        if (op[OP_EN_BIT])
            decode_mode = MODE_READY;
        else if (op == (8'h01 << OP_WU_BIT))
            decode_mode = MODE_WAKEUP;
        else
            decode_mode = MODE_POWER_DOWN;
    endfunction : decode_mode

    function automatic logic ram_hit(input logic [ADDR_W-1:0] a);
        ram_hit = (a >= OFS_PT_RAM) && (a < OFS_PT_RAM + 8'(PT_RAM_DEPTH));
    endfunction : ram_hit

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [7:0]       op_ctrl_reg;
    logic [7:0]       io_cfg1_reg;
    logic [7:0]       io_cfg2_reg;
    logic [7:0]       wu_ctrl_reg;
    logic [7:0]       ref_reg [3];
    logic [IRQ_W-1:0] irq_stat_reg;
    logic [IRQ_W-1:0] irq_stat_next;
    logic [IRQ_W-1:0] irq_mask_reg;
    logic [7:0]       pt_ram_reg [PT_RAM_DEPTH];
    op_mode_t         mode_reg;
    wu_state_t        wu_state_reg;
    logic [1:0]       sel_reg;
    logic [2:0]       osc_sync_reg;
    logic [2:0]       rc_sync_reg;
    logic [2:0]       done_sync_reg;
    logic [7:0]       val_meta_reg;
    logic [7:0]       val_sync_reg;
    logic             osc_rise;
    logic             rc_edge;
    logic             done_rise;
    logic             wu_tick;
    logic             cmp_fire;
    logic             cmp_diff;
    logic             wr_en;
    logic             rd_en;
    logic             ram_ok;
    logic             access_bad;
    logic [1:0]       ram_idx;
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;

    assign wr_en   = reg_req_i.wr;
    assign rd_en   = reg_req_i.rd;
    assign ram_idx = reg_req_i.addr[1:0];
    assign ram_ok  = op_ctrl_reg[OP_EN_BIT];

    // ------------------------------------------------------------------
    // Synchronisers for pins and the RC oscillator
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            osc_sync_reg  <= 3'h0;
            rc_sync_reg   <= 3'h0;
            done_sync_reg <= 3'h0;
            val_meta_reg  <= 8'h00;
            val_sync_reg  <= 8'h00;
        end
        else
        begin
            osc_sync_reg  <= {osc_sync_reg[1:0], osc_ok_i};
            rc_sync_reg   <= {rc_sync_reg[1:0], rc_clk_i};
            done_sync_reg <= {done_sync_reg[1:0], meas_done_i};
            // Value is held stable by the sensor while done is high
            val_meta_reg  <= meas_value_i;
            val_sync_reg  <= val_meta_reg;
        end
    end

    assign osc_rise  = osc_sync_reg[1] && !osc_sync_reg[2];
    assign rc_edge   = rc_sync_reg[1] && !rc_sync_reg[2];
    assign done_rise = done_sync_reg[1] && !done_sync_reg[2];

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            op_ctrl_reg  <= OP_CTRL_RST;
            io_cfg1_reg  <= IO_CFG_RST;
            io_cfg2_reg  <= IO_CFG_RST;
            wu_ctrl_reg  <= WU_CTRL_RST;
            ref_reg[0]   <= REF_RST;
            ref_reg[1]   <= REF_RST;
            ref_reg[2]   <= REF_RST;
            irq_mask_reg <= IRQ_RST;
        end
        else if (wr_en)
        begin
            // Accepted in every mode, power-down included
            case (reg_req_i.addr)
                OFS_OP_CTRL:   op_ctrl_reg  <= reg_req_i.wdata;
                OFS_IO_CFG1:   io_cfg1_reg  <= reg_req_i.wdata;
                OFS_IO_CFG2:   io_cfg2_reg  <= reg_req_i.wdata;
                OFS_WU_CTRL:   wu_ctrl_reg  <= reg_req_i.wdata;
                OFS_REF_CAP:   ref_reg[0]   <= reg_req_i.wdata;
                OFS_REF_PHASE: ref_reg[1]   <= reg_req_i.wdata;
                OFS_REF_AMPL:  ref_reg[2]   <= reg_req_i.wdata;
                OFS_IRQ_MASK:
                    irq_mask_reg <= reg_req_i.wdata[IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Passive target RAM and FIFO port
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            for (int i = 0; i < PT_RAM_DEPTH; i++)
                pt_ram_reg[i] <= 8'h00;
        end
        else if (wr_en && ram_hit(reg_req_i.addr) && ram_ok)
        begin
            pt_ram_reg[ram_idx] <= reg_req_i.wdata;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            fifo_push_o  <= 1'b0;
            fifo_pop_o   <= 1'b0;
            fifo_wdata_o <= 8'h00;
        end
        else
        begin
            // Refused while powered down: no strobe reaches the FIFO
            fifo_push_o <= wr_en && ram_ok
                           && (reg_req_i.addr == OFS_FIFO_DATA);
            fifo_pop_o  <= rd_en && ram_ok
                           && (reg_req_i.addr == OFS_FIFO_DATA);
            if (wr_en && (reg_req_i.addr == OFS_FIFO_DATA))
                fifo_wdata_o <= reg_req_i.wdata;
        end
    end

    assign access_bad = (wr_en || rd_en) && !ram_ok
                        && (ram_hit(reg_req_i.addr)
                            || reg_req_i.addr == OFS_FIFO_DATA);

    // ------------------------------------------------------------------
    // Read data, valid only in the cycle after the strobe
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rdata_o <= 8'h00;
        else if (!rd_en)
            rdata_o <= 8'h00;
        else if (ram_hit(reg_req_i.addr))
            rdata_o <= ram_ok ? pt_ram_reg[ram_idx] : 8'h00;
        else
        begin
            case (reg_req_i.addr)
                OFS_OP_CTRL:   rdata_o <= op_ctrl_reg;
                OFS_IO_CFG1:   rdata_o <= io_cfg1_reg;
                OFS_IO_CFG2:   rdata_o <= io_cfg2_reg;
                OFS_WU_CTRL:   rdata_o <= wu_ctrl_reg;
                OFS_REF_CAP:   rdata_o <= ref_reg[0];
                OFS_REF_PHASE: rdata_o <= ref_reg[1];
                OFS_REF_AMPL:  rdata_o <= ref_reg[2];
                OFS_IRQ_STAT:  rdata_o <= {3'h0, irq_stat_reg};
                OFS_IRQ_MASK:  rdata_o <= {3'h0, irq_mask_reg};
                OFS_MODE_STAT:
                    rdata_o <= {5'h00, osc_sync_reg[2], 2'(mode_reg)};
                OFS_FIFO_DATA: rdata_o <= ram_ok ? fifo_rdata_i : 8'h00;
                default:       rdata_o <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Mode and power controls
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            mode_reg    <= MODE_POWER_DOWN;
            mode_o      <= MODE_POWER_DOWN;
            power_ctl_o <= '0;
        end
        else
        begin
            mode_reg              <= decode_mode(op_ctrl_reg);
            mode_o                <= decode_mode(op_ctrl_reg);
            power_ctl_o.osc_en    <= op_ctrl_reg[OP_EN_BIT];
            power_ctl_o.reg_en    <= op_ctrl_reg[OP_EN_BIT];
            power_ctl_o.aat_en    <= op_ctrl_reg[OP_EN_BIT];
            // Receive and transmit paths need the oscillator running
            power_ctl_o.rx_en     <= op_ctrl_reg[OP_EN_BIT]
                                     && op_ctrl_reg[OP_RX_BIT];
            power_ctl_o.tx_en     <= op_ctrl_reg[OP_EN_BIT]
                                     && op_ctrl_reg[OP_TX_BIT];
            power_ctl_o.rc_osc_en <= (decode_mode(op_ctrl_reg)
                                      == MODE_WAKEUP);
        end
    end

    // ------------------------------------------------------------------
    // Wake-up measurement scheduling
    // ------------------------------------------------------------------
    wakeup_timer u_wakeup_timer (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_i),
        .run_i     (mode_reg == MODE_WAKEUP),
        .rc_edge_i (rc_edge),
        .period_i  (wu_ctrl_reg[WU_PER_LSB +: WU_PER_W]),
        .tick_o    (wu_tick)
    );

    assign cmp_fire = (wu_state_reg == WU_WAIT) && done_rise;
    assign cmp_diff = val_sync_reg != ref_reg[sel_reg];

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wu_state_reg <= WU_IDLE;
            sel_reg      <= 2'h0;
            meas_start_o <= 1'b0;
            meas_sel_o   <= 2'h0;
        end
        else
        begin
            meas_start_o <= 1'b0;
            if (mode_reg != MODE_WAKEUP)
                wu_state_reg <= WU_IDLE;
            else
            begin
                case (wu_state_reg)
                    WU_IDLE:
                        if (wu_tick)
                        begin
                            sel_reg      <= 2'h0;
                            wu_state_reg <= WU_CHECK;
                        end
                    WU_CHECK:
                        // Capacitive, phase, amplitude in that order
                        if (sel_reg == 2'h3)
                            wu_state_reg <= WU_IDLE;
                        else if (wu_ctrl_reg[sel_reg])
                        begin
                            meas_start_o <= 1'b1;
                            meas_sel_o   <= sel_reg;
                            wu_state_reg <= WU_WAIT;
                        end
                        else
                            sel_reg <= sel_reg + 2'h1;
                    WU_WAIT:
                        if (done_rise)
                        begin
                            sel_reg      <= sel_reg + 2'h1;
                            wu_state_reg <= WU_CHECK;
                        end
                    default: wu_state_reg <= WU_IDLE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status, mask and output
    // ------------------------------------------------------------------
    always_comb
    begin
        irq_set = '0;
        irq_set[IRQ_OSC_BIT] = osc_rise && (mode_reg == MODE_READY);
        if (cmp_fire && cmp_diff)
            irq_set[IRQ_MEAS_LSB + int'(sel_reg)] = 1'b1;
        irq_set[IRQ_ACC_BIT] = access_bad;
        irq_clr = (wr_en && reg_req_i.addr == OFS_IRQ_STAT)
                  ? reg_req_i.wdata[IRQ_W-1:0] : '0;
        // A new event wins over a clear in the same cycle
        irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_set;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            irq_stat_reg <= IRQ_RST;
            irq_o        <= 1'b0;
        end
        else
        begin
            irq_stat_reg <= irq_stat_next;
            irq_o        <= |(irq_stat_next & irq_mask_reg);
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_osc_ready;
        osc_rise && mode_reg == MODE_READY;
    endsequence

    sequence s_meas_miss;
        cmp_fire && cmp_diff;
    endsequence

    a_en_gates_power: assert property (
        ##1 power_ctl_o.osc_en == $past(op_ctrl_reg[OP_EN_BIT])
            && power_ctl_o.aat_en == power_ctl_o.reg_en)
        else $error("power enables do not follow enable bit");
    a_ready_mode_on: assert property (
        op_ctrl_reg[OP_EN_BIT] |=> mode_reg == MODE_READY
                                   && power_ctl_o.osc_en)
        else $error("enable bit did not give ready mode");
    a_osc_stable_irq: assert property (
        s_osc_ready |=> irq_stat_reg[IRQ_OSC_BIT])
        else $error("oscillator stable event not latched");
    a_cfg_write_pd: assert property (
        wr_en && reg_req_i.addr == OFS_IO_CFG1 && mode_reg != MODE_READY
        |=> io_cfg1_reg == $past(reg_req_i.wdata))
        else $error("configuration write lost in power-down");
    a_ram_blocked: assert property (
        rd_en && ram_hit(reg_req_i.addr) && !ram_ok |=> rdata_o == 8'h00)
        else $error("target RAM readable while powered down");
    a_fifo_blocked: assert property (
        !ram_ok |=> !fifo_push_o && !fifo_pop_o)
        else $error("FIFO strobe while powered down");
    a_ram_open: assert property (
        wr_en && ram_hit(reg_req_i.addr) && ram_ok
        ##1 rd_en && $past(reg_req_i.addr) == reg_req_i.addr
        |=> rdata_o == $past(reg_req_i.wdata, 2))
        else $error("target RAM write not read back");
    a_rx_tx_split: assert property (
        op_ctrl_reg[OP_EN_BIT] && op_ctrl_reg[OP_RX_BIT]
        && !op_ctrl_reg[OP_TX_BIT]
        |=> power_ctl_o.rx_en && !power_ctl_o.tx_en)
        else $error("receiver and transmitter not independent");
    a_wu_only_bit: assert property (
        op_ctrl_reg == (8'h01 << OP_WU_BIT)
        |=> mode_reg == MODE_WAKEUP && power_ctl_o.rc_osc_en)
        else $error("lone wake-up bit did not enter wake-up mode");
    a_wu_combined: assert property (
        op_ctrl_reg[OP_WU_BIT] && op_ctrl_reg != (8'h01 << OP_WU_BIT)
        |=> mode_reg != MODE_WAKEUP)
        else $error("wake-up mode entered with other bits set");
    a_meas_diff_irq: assert property (
        s_meas_miss |=> irq_stat_reg[IRQ_MEAS_LSB + int'($past(sel_reg))])
        else $error("measurement difference not latched");
    a_irq_level: assert property (
        ##1 irq_o == |($past(irq_stat_next) & $past(irq_mask_reg)))
        else $error("interrupt output disagrees with status");

endmodule : rf_frontend_mode_control

// File: design/rf_mode_pkg.sv
// Shared constants and types of the front-end operating-mode controller
package rf_mode_pkg;

    // ------------------------------------------------------------------
    // Register bus geometry and offsets
    // ------------------------------------------------------------------
    localparam int         ADDR_W        = 8;
    localparam int         DATA_W        = 8;
    localparam logic [7:0] OFS_OP_CTRL   = 8'h00;
    localparam logic [7:0] OFS_IO_CFG1   = 8'h01;
    localparam logic [7:0] OFS_IO_CFG2   = 8'h02;
    localparam logic [7:0] OFS_WU_CTRL   = 8'h03;
    localparam logic [7:0] OFS_REF_CAP   = 8'h04;
    localparam logic [7:0] OFS_REF_PHASE = 8'h05;
    localparam logic [7:0] OFS_REF_AMPL  = 8'h06;
    localparam logic [7:0] OFS_IRQ_STAT  = 8'h07;
    localparam logic [7:0] OFS_IRQ_MASK  = 8'h08;
    localparam logic [7:0] OFS_MODE_STAT = 8'h09;
    localparam logic [7:0] OFS_PT_RAM    = 8'h10;
    localparam logic [7:0] OFS_FIFO_DATA = 8'h14;
    localparam int         PT_RAM_DEPTH  = 4;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int OP_EN_BIT    = 7;
    localparam int OP_RX_BIT    = 6;
    localparam int OP_TX_BIT    = 3;
    localparam int OP_WU_BIT    = 2;
    localparam int WU_PER_LSB   = 4;
    localparam int WU_PER_W     = 4;
    localparam int IRQ_OSC_BIT  = 0;
    localparam int IRQ_MEAS_LSB = 1;
    localparam int IRQ_ACC_BIT  = 4;
    localparam int IRQ_W        = 5;

    // ------------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------------
    localparam logic [7:0]       OP_CTRL_RST  = 8'h00;
    localparam logic [7:0]       IO_CFG_RST   = 8'h00;
    localparam logic [7:0]       WU_CTRL_RST  = 8'h00;
    localparam logic [7:0]       REF_RST      = 8'h00;
    localparam logic [IRQ_W-1:0] IRQ_RST      = 5'h00;
    localparam logic [7:0]       RC_EDGES_PER_UNIT = 8'h08;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_POWER_DOWN,
        MODE_READY,
        MODE_WAKEUP
    } op_mode_t;

    typedef enum logic [1:0] {
        WU_IDLE,
        WU_CHECK,
        WU_WAIT
    } wu_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } reg_req_t;

    typedef struct packed {
        logic osc_en;
        logic reg_en;
        logic aat_en;
        logic rx_en;
        logic tx_en;
        logic rc_osc_en;
    } power_ctl_t;

endpackage : rf_mode_pkg

// File: design/wakeup_timer.sv
// Wake-up timer counting edges of the low-power RC oscillator
module wakeup_timer
    import rf_mode_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic                rst_n_i,
    input  wire logic                run_i,
    input  wire logic                rc_edge_i,
    input  wire logic [WU_PER_W-1:0] period_i,
    output logic                     tick_o
);

    logic [7:0]          unit_cnt_reg;
    logic [WU_PER_W-1:0] per_cnt_reg;

    // Interval is (period + 1) units of RC edges
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            unit_cnt_reg <= 8'h00;
            per_cnt_reg  <= '0;
            tick_o       <= 1'b0;
        end
        else
        begin
            tick_o <= 1'b0;
            if (!run_i)
            begin
                unit_cnt_reg <= 8'h00;
                per_cnt_reg  <= '0;
            end
            else if (rc_edge_i)
            begin
                if (unit_cnt_reg == RC_EDGES_PER_UNIT - 8'h01)
                begin
                    unit_cnt_reg <= 8'h00;
                    if (per_cnt_reg == period_i)
                    begin
                        per_cnt_reg <= '0;
                        tick_o      <= 1'b1;
                    end
                    else
                    begin
                        per_cnt_reg <= per_cnt_reg + 1'b1;
                    end
                end
                else
                begin
                    unit_cnt_reg <= unit_cnt_reg + 8'h01;
                end
            end
        end
    end

endmodule : wakeup_timer

// File: tb/meas_side_model.sv
// Analog side model: crystal oscillator, RC oscillator and measurements
module meas_side_model
    import rf_mode_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire power_ctl_t power_ctl_i,
    input  wire logic       meas_start_i,
    input  wire logic [1:0] meas_sel_i,
    output logic            osc_ok_o,
    output logic            rc_clk_o,
    output logic            meas_done_o,
    output logic [7:0]      meas_value_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       rc_free = 1'b0;
    logic [3:0] osc_cnt;
    logic [3:0] m_cnt;
    // RC clock stands still while the device keeps it off
    always #80 rc_free = ~rc_free;
    assign rc_clk_o    = rc_free & power_ctl_i.rc_osc_en;
    assign osc_ok_o    = (osc_cnt == 4'hF);
    assign meas_done_o = (m_cnt >= 4'h4) && (m_cnt <= 4'h9);
    always_ff @(posedge clk_i or negedge rst_n_i)
        if (!rst_n_i) osc_cnt <= 4'h0;
        else if (!power_ctl_i.osc_en) osc_cnt <= 4'h0;
        else if (osc_cnt != 4'hF) osc_cnt <= osc_cnt + 4'h1;
    always_ff @(posedge clk_i or negedge rst_n_i)
        if (!rst_n_i) m_cnt <= 4'h0;
        else if (meas_start_i) m_cnt <= 4'h1;
        else if (m_cnt != 4'h0) m_cnt <= m_cnt + 4'h1;
    // Result valid around done, garbage after it falls
    always_ff @(posedge clk_i)
        if (meas_start_i) meas_value_o <= 8'h20 + {6'h00, meas_sel_i};
        else if (m_cnt == 4'hA) meas_value_o <= ~meas_value_o;
endmodule : meas_side_model

// File: tb/tb_rf_frontend_mode_control.sv
// Register-level bench of the operating-mode controller
module tb_rf_frontend_mode_control;
    import rf_mode_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_n = 1'b0, osc_ok, rc_clk, done, push, pop;
    logic start, irq;
    reg_req_t req = '0;
    logic [7:0] rdata, mval, wdata;
    logic [1:0] sel;
    power_ctl_t pwr;
    op_mode_t mode;
    int errors = 0, num_checks = 0, cyc = 0, pushes = 0, pops = 0;
    always #10 clk = ~clk;
    rf_frontend_mode_control dut (.clk_i(clk), .rst_n_i(rst_n),
        .reg_req_i(req), .rdata_o(rdata), .osc_ok_i(osc_ok),
        .rc_clk_i(rc_clk), .meas_done_i(done), .meas_value_i(mval),
        .fifo_rdata_i(8'hA5), .power_ctl_o(pwr), .mode_o(mode),
        .meas_start_o(start), .meas_sel_o(sel), .fifo_push_o(push),
        .fifo_pop_o(pop), .fifo_wdata_o(wdata), .irq_o(irq));
    meas_side_model model (.clk_i(clk), .rst_n_i(rst_n),
        .power_ctl_i(pwr), .meas_start_i(start), .meas_sel_i(sel),
        .osc_ok_o(osc_ok), .rc_clk_o(rc_clk), .meas_done_o(done),
        .meas_value_o(mval));
    // -----------------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------------
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        pushes <= pushes + (push === 1'b1);
        pops <= pops + (pop === 1'b1);
        if (cyc == 20000)
        begin
            errors = errors + 1;
            results();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk) req <= '0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk) req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk) req <= '0;
        #1 chk(rdata, exp);
    endtask : rd
    task automatic outs(input logic [7:0] m, input logic [7:0] p);
        repeat (2) @(posedge clk);
        #1 chk({6'h00, mode}, m);
        chk({2'h0, pwr}, p);
    endtask : outs
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : results
    // -----------------------------------------------------------------
    // Tests
    // -----------------------------------------------------------------
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        #1 chk({6'h00, mode}, 8'h00);
        chk({2'h0, pwr}, 8'h00);
        wr(8'h04, 8'h10);
        rd(OFS_OP_CTRL, OP_CTRL_RST);
        rd(OFS_IO_CFG2, IO_CFG_RST);
        wr(OFS_IO_CFG1, 8'h5A);
        wr(OFS_IO_CFG2, 8'hC3);
        rd(OFS_IO_CFG1, 8'h5A);
        rd(OFS_IO_CFG2, 8'hC3);
        wr(OFS_PT_RAM, 8'h3C);
        wr(OFS_FIFO_DATA, 8'h11);
        rd(OFS_FIFO_DATA, 8'h00);
        rd(OFS_PT_RAM, 8'h00);
        @(posedge clk) #1 chk(8'(pushes + pops), 8'h00);
        rd(OFS_IRQ_STAT, 8'h10);
        wr(OFS_IRQ_STAT, 8'h10);
        $display("power-down test done");
        wr(OFS_IRQ_MASK, 8'h05);
        wr(OFS_OP_CTRL, 8'h80);
        outs(8'h01, 8'h38);
        repeat (25) @(posedge clk);
        rd(OFS_IRQ_STAT, 8'h01);
        chk({7'h00, irq}, 8'h01);
        wr(OFS_IRQ_STAT, 8'h01);
        #1 chk({7'h00, irq}, 8'h00);
        wr(OFS_PT_RAM, 8'h3C);
        rd(OFS_PT_RAM, 8'h3C);
        wr(OFS_FIFO_DATA, 8'h77);
        #1 chk(wdata, 8'h77);
        rd(OFS_FIFO_DATA, 8'hA5);
        @(posedge clk) #1 chk(8'(pushes + pops * 2), 8'h03);
        $display("ready test done");
        wr(OFS_OP_CTRL, 8'hC0);
        outs(8'h01, 8'h3C);
        wr(OFS_OP_CTRL, 8'h88);
        outs(8'h01, 8'h3A);
        wr(OFS_OP_CTRL, 8'h84);
        outs(8'h01, 8'h38);
        wr(OFS_OP_CTRL, 8'h0C);
        outs(8'h00, 8'h00);
        $display("enable test done");
        wr(OFS_REF_CAP, 8'h20);
        wr(OFS_REF_PHASE, 8'h00);
        wr(OFS_REF_AMPL, 8'h22);
        wr(OFS_WU_CTRL, 8'h07);
        wr(OFS_OP_CTRL, 8'h04);
        outs(8'h02, 8'h01);
        repeat (300) @(posedge clk);
        rd(OFS_IRQ_STAT, 8'h04);
        chk({7'h00, irq}, 8'h01);
        $display("wake-up test done");
        results();
    end
endmodule : tb_rf_frontend_mode_control
